// File: logic/ctr_timer_regs.sv
// Charge phase, charge timer and battery-powered output configuration bank.
// Assumes scl/sda synchronous to ref_clk and an external open-drain sda pad.
`timescale 1ns/1ps
`default_nettype none
module ctr_timer_regs #(
   parameter int         CYC_PER_MS = ctr_pkg::CYC_PER_MS,
   parameter logic [6:0] DEV_ADDR   = 7'h2a  // Arbitrary value
) (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic [1:0]  cell_strap,
   input  wire logic [2:0]  wd_period_code,
   input  wire logic        input_power_limiting,
   input  wire logic        thermal_reg_active,
   output logic [1:0]       fast_charge_entry_ratio,
   output logic [5:0]       precharge_current,
   output logic [4:0]       termination_current,
   output logic [1:0]       cell_count,
   output logic [1:0]       recharge_deglitch,
   output logic [3:0]       recharge_offset,
   output logic [10:0]      output_voltage_target,
   output logic [6:0]       output_current_limit,
   output logic             precharge_timer_length,
   output logic [1:0]       topoff_duration,
   output logic             trickle_timer_enable,
   output logic             precharge_timer_enable,
   output logic             fast_timer_enable,
   output logic [1:0]       fast_timer_length,
   output logic             timer_slowdown_enable,
   output logic             timer_half_rate,
   output logic [10:0]      battery_regulation_limit,
   output logic             timer_restart,
   output logic             wd_expired
);
   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   logic        strap_done_ff;
   logic [7:0]  prechg_ff;
   logic [6:0]  term_ff;
   logic [7:0]  rechg_ff;
   logic [10:0] vout_ff;
   logic [7:0]  iout_ff;
   logic [7:0]  tmr_ff;
   logic [10:0] blim_ff;
   logic        half_ff;
   logic        restart_ff;
   logic [7:0]  nxt_prechg;
   logic [6:0]  nxt_term;
   logic [7:0]  nxt_rechg;
   logic [10:0] nxt_vout;
   logic [7:0]  nxt_iout;
   logic [7:0]  nxt_tmr;
   logic [10:0] nxt_blim;
   logic        wd_fire;

   ctr_reg_if bus ();

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   ctr_i2c_slave #(
      .DEV_ADDR    (DEV_ADDR)
   ) u_slave (
      .clk         (ref_clk),
      .rst_n       (rst_n),
      .scl         (scl),
      .sda_in      (sda_in),
      .sda_oe_n    (sda_oe_n),
      .regs        (bus.master)
   );

   // Any host write or soft reset restarts the watchdog
   ctr_watchdog #(
      .CYC_PER_MS  (CYC_PER_MS)
   ) u_wd (
      .clk         (ref_clk),
      .rst_n       (rst_n),
      .kick        (bus.wr_stb | restart_ff),
      .period_code (wd_period_code),
      .expire_ff   (wd_fire)
   );

   // Address decode of host writes
   wire wr_prechg = bus.wr_stb & (bus.addr == ctr_pkg::OFS_PRECHG);
   wire wr_term   = bus.wr_stb & (bus.addr == ctr_pkg::OFS_TERM);
   wire wr_rechg  = bus.wr_stb & (bus.addr == ctr_pkg::OFS_RECHG);
   wire wr_vhi    = bus.wr_stb & (bus.addr == ctr_pkg::OFS_VOUT_HI);
   wire wr_vlo    = bus.wr_stb & (bus.addr == ctr_pkg::OFS_VOUT_LO);
   wire wr_iout   = bus.wr_stb & (bus.addr == ctr_pkg::OFS_IOUT);
   wire wr_tmr    = bus.wr_stb & (bus.addr == ctr_pkg::OFS_TMR);

   // Full restore on strap capture or a pending soft reset
   wire restore_all = ~strap_done_ff | term_ff[ctr_pkg::SOFT_RST_BIT];

   // Clamped write values
   wire [5:0]  w_pre  = (bus.wdata[5:0] < ctr_pkg::PRECHG_MIN) ? ctr_pkg::PRECHG_MIN
                                                               : bus.wdata[5:0];
   wire [4:0]  w_term = (bus.wdata[4:0] < ctr_pkg::TERM_MIN) ? ctr_pkg::TERM_MIN
                                                             : bus.wdata[4:0];
   wire [6:0]  w_iout = (bus.wdata[6:0] < ctr_pkg::IOUT_MIN) ? ctr_pkg::IOUT_MIN
                                                             : bus.wdata[6:0];
   wire [10:0] w_vraw = wr_vhi ? {bus.wdata[2:0], vout_ff[7:0]}
                               : {vout_ff[10:8], bus.wdata};
   wire [10:0] w_vout = (w_vraw > ctr_pkg::VOUT_MAX) ? ctr_pkg::VOUT_MAX : w_vraw;

   // Next register values: restore, then watchdog, then host write
   always_comb begin
      nxt_prechg = prechg_ff;
      nxt_term   = term_ff;
      nxt_rechg  = rechg_ff;
      nxt_vout   = vout_ff;
      nxt_iout   = iout_ff;
      nxt_tmr    = tmr_ff;
      nxt_blim   = blim_ff;
      if (restore_all) begin
         nxt_prechg = ctr_pkg::RST_PRECHG;
         nxt_term   = ctr_pkg::RST_TERM;
         nxt_rechg  = {cell_strap, ctr_pkg::RST_RECHG};
         nxt_vout   = ctr_pkg::RST_VOUT;
         nxt_iout   = ctr_pkg::RST_IOUT;
         nxt_tmr    = ctr_pkg::RST_TMR;
         nxt_blim   = ctr_pkg::blim_default(cell_strap);
      end else if (wd_fire) begin
         nxt_prechg = {prechg_ff[7:6], ctr_pkg::RST_PRECHG[5:0]};
         nxt_term   = {term_ff[6:5], ctr_pkg::RST_TERM[4:0]};
         nxt_rechg  = {rechg_ff[7:6], ctr_pkg::RST_RECHG};
         nxt_vout   = ctr_pkg::RST_VOUT;
         nxt_iout   = ctr_pkg::RST_IOUT;
         nxt_tmr    = ctr_pkg::RST_TMR;
      end else begin
         if (wr_prechg) begin
            nxt_prechg = {bus.wdata[7:6], w_pre};
         end
         if (wr_term) begin
            nxt_term = {bus.wdata[6:5], w_term};
         end
         if (wr_rechg) begin
            nxt_rechg = bus.wdata;
         end
         if (wr_vhi | wr_vlo) begin
            nxt_vout = w_vout;
         end
         if (wr_iout) begin
            nxt_iout = {bus.wdata[7], w_iout};
         end
         if (wr_tmr) begin
            nxt_tmr = bus.wdata;
         end
      end
   end

   // Register bank
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_ff <= 1'b0;
         prechg_ff     <= ctr_pkg::RST_PRECHG;
         term_ff       <= ctr_pkg::RST_TERM;
         rechg_ff      <= {2'b00, ctr_pkg::RST_RECHG};
         vout_ff       <= ctr_pkg::RST_VOUT;
         iout_ff       <= ctr_pkg::RST_IOUT;
         tmr_ff        <= ctr_pkg::RST_TMR;
         blim_ff       <= ctr_pkg::blim_default(2'b00);
      end else begin
         strap_done_ff <= 1'b1;
         prechg_ff     <= nxt_prechg;
         term_ff       <= nxt_term;
         rechg_ff      <= nxt_rechg;
         vout_ff       <= nxt_vout;
         iout_ff       <= nxt_iout;
         tmr_ff        <= nxt_tmr;
         blim_ff       <= nxt_blim;
      end
   end

   // Timer restart, watchdog flag and half-rate timing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_ff <= 1'b0;
         wd_expired <= 1'b0;
         half_ff    <= 1'b0;
      end else begin
         restart_ff <= term_ff[ctr_pkg::SOFT_RST_BIT];
         wd_expired <= wd_fire;
         half_ff    <= tmr_ff[ctr_pkg::SLOW_BIT]
                       & (input_power_limiting | thermal_reg_active);
      end
   end

   // Read mux; reserved bits and unmapped offsets read zero
   always_comb begin
      case (bus.addr)
         ctr_pkg::OFS_PRECHG:  bus.rdata = prechg_ff;
         ctr_pkg::OFS_TERM:    bus.rdata = {1'b0, term_ff};
         ctr_pkg::OFS_RECHG:   bus.rdata = rechg_ff;
         ctr_pkg::OFS_VOUT_HI: bus.rdata = {5'h00, vout_ff[10:8]};
         ctr_pkg::OFS_VOUT_LO: bus.rdata = vout_ff[7:0];
         ctr_pkg::OFS_IOUT:    bus.rdata = iout_ff;
         ctr_pkg::OFS_TMR:     bus.rdata = tmr_ff;
         default:              bus.rdata = 8'h00;
      endcase
   end

   // Field outputs, taken from bank flops and the half-rate and restart flops; sda_out is tied low
   assign sda_out                  = 1'b0;  // Open drain: only ever pulls low
   assign fast_charge_entry_ratio  = prechg_ff[7:6];
   assign precharge_current        = prechg_ff[5:0];
   assign termination_current      = term_ff[4:0];
   assign cell_count               = rechg_ff[7:6];
   assign recharge_deglitch        = rechg_ff[5:4];
   assign recharge_offset          = rechg_ff[3:0];
   assign output_voltage_target    = vout_ff;
   assign output_current_limit     = iout_ff[6:0];
   assign precharge_timer_length   = iout_ff[7];
   assign topoff_duration          = tmr_ff[7:6];
   assign trickle_timer_enable     = tmr_ff[ctr_pkg::EN_TRI_BIT];
   assign precharge_timer_enable   = tmr_ff[ctr_pkg::EN_PRE_BIT];
   assign fast_timer_enable        = tmr_ff[ctr_pkg::EN_FAST_BIT];
   assign fast_timer_length        = tmr_ff[2:1];
   assign timer_slowdown_enable    = tmr_ff[ctr_pkg::SLOW_BIT];
   assign timer_half_rate          = half_ff;
   assign battery_regulation_limit = blim_ff;
   assign timer_restart            = restart_ff;
endmodule : ctr_timer_regs
`default_nettype wire

// File: logic/ctr_pkg.sv
// Constants, field layout and types of the charge timer configuration bank.
// Assumes a 20 MHz reference clock and a two-wire serial host bus.
// How it works
// - Threshold code picks fast-charge entry ratio
// - Precharge current 40 mA steps, clamped low
// - Writing soft reset bit restores all defaults
// - Termination current 40 mA steps, clamped low
// - Cell count sensed at power-on, host-writable
// - Recharge deglitch code, default 1024 ms
// - Recharge offset 50 mV plus 50 mV/code
// - Output voltage 2800 mV base, clamped high
// - Output current 40 mA steps, min 120 mA
// - One bit picks precharge timer 2h/0.5h
// - Top-off timer off by default, 15/30/45 min
// - Trickle timer enable, fixed one hour
// - Precharge and fast timer enables bits 4,3
// - Fast timer length 5/8/12/24 hours
// - Slowdown bit halves timers while limited
// - Regulation limit default from cell count
// - Watchdog period code, zero disables
`default_nettype none
package ctr_pkg;
   // Register offsets on the serial bus
   localparam logic [7:0]  OFS_PRECHG  = 8'h08;
   localparam logic [7:0]  OFS_TERM    = 8'h09;
   localparam logic [7:0]  OFS_RECHG   = 8'h0a;
   localparam logic [7:0]  OFS_VOUT_HI = 8'h0b;
   localparam logic [7:0]  OFS_VOUT_LO = 8'h0c;
   localparam logic [7:0]  OFS_IOUT    = 8'h0d;
   localparam logic [7:0]  OFS_TMR     = 8'h0e;
   // Values after reset
   localparam logic [7:0]  RST_PRECHG  = 8'hc3;
   localparam logic [6:0]  RST_TERM    = 7'h05;
   localparam logic [5:0]  RST_RECHG   = 6'h23;
   localparam logic [10:0] RST_VOUT    = 11'h0dc;
   localparam logic [7:0]  RST_IOUT    = 8'h4b;
   localparam logic [7:0]  RST_TMR     = 8'h3d;
   // Field positions
   localparam int          SOFT_RST_BIT = 6;
   localparam int          EN_TRI_BIT   = 5;
   localparam int          EN_PRE_BIT   = 4;
   localparam int          EN_FAST_BIT  = 3;
   localparam int          SLOW_BIT     = 0;
   // Clamp limits in codes
   localparam logic [5:0]  PRECHG_MIN  = 6'h01;
   localparam logic [4:0]  TERM_MIN    = 5'h01;
   localparam logic [6:0]  IOUT_MIN    = 7'h03;
   localparam logic [10:0] VOUT_MAX    = 11'h780;
   // Clock and watchdog timing
   localparam int          CLK_HZ      = 20000000;
   localparam int          MS_PER_S    = 1000;
   localparam int          CYC_PER_MS  = CLK_HZ / MS_PER_S;
   localparam int          WD_MS_W     = 18;

   typedef enum logic [5:0] {
      I2C_IDLE = 6'h01,
      I2C_ADDR = 6'h02,
      I2C_ACK  = 6'h04,
      I2C_WR   = 6'h08,
      I2C_RD   = 6'h10,
      I2C_RACK = 6'h20
   } ctr_i2c_state_type;

   // Regulation limit default per cell count, 10 mV codes
   function automatic logic [10:0] blim_default(input logic [1:0] cells);
      case (cells)
         2'h0:    blim_default = 11'h1a4;
         2'h1:    blim_default = 11'h348;
         2'h2:    blim_default = 11'h4ec;
         default: blim_default = 11'h690;
      endcase
   endfunction : blim_default

   // Watchdog period in ms per code
   function automatic logic [WD_MS_W-1:0] wd_limit_ms(input logic [2:0] code);
      case (code)
         3'h1:    wd_limit_ms = 18'h001f4;
         3'h2:    wd_limit_ms = 18'h003e8;
         3'h3:    wd_limit_ms = 18'h007d0;
         3'h4:    wd_limit_ms = 18'h04e20;
         3'h5:    wd_limit_ms = 18'h09c40;
         3'h6:    wd_limit_ms = 18'h13880;
         3'h7:    wd_limit_ms = 18'h27100;
         default: wd_limit_ms = 18'h00000;
      endcase
   endfunction : wd_limit_ms
endpackage : ctr_pkg
`default_nettype wire

// File: logic/ctr_reg_if.sv
// Register access carrier between the serial slave and the register bank.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface ctr_reg_if;
   logic [7:0] addr;
   logic       wr_stb;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport master (output addr, output wr_stb, output wdata, input rdata);
   modport slave  (input addr, input wr_stb, input wdata, output rdata);
endinterface : ctr_reg_if
`default_nettype wire

// File: logic/ctr_i2c_slave.sv
// Two-wire serial slave: device address, register pointer, auto-increment.
// Assumes scl and sda inputs synchronous to clk; sda is open drain.
`timescale 1ns/1ps
`default_nettype none
module ctr_i2c_slave #(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary value
) (
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire logic     scl,
   input  wire logic     sda_in,
   output logic          sda_oe_n,
   ctr_reg_if.master     regs
);
   ctr_pkg::ctr_i2c_state_type st_ff;
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic [2:0] bit_ff;
   logic [7:0] shift_ff;
   logic [7:0] ptr_ff;
   logic       rw_ff;
   logic       first_ff;
   logic       acked_ff;
   logic       wr_ff;
   logic [7:0] wd_ff;

   // Bus conditions
   wire       scl_rise = ~scl_q_ff & scl;
   wire       scl_fall = scl_q_ff & ~scl;
   wire       start_c  = scl_q_ff & scl & sda_q_ff & ~sda_in;
   wire       stop_c   = scl_q_ff & scl & ~sda_q_ff & sda_in;
   wire [7:0] rx_byte  = {shift_ff[6:0], sda_in};

   assign regs.addr   = ptr_ff;
   assign regs.wr_stb = wr_ff;
   assign regs.wdata  = wd_ff;

   // Bit and byte sequencing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff    <= ctr_pkg::I2C_IDLE;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         bit_ff   <= 3'h0;
         shift_ff <= 8'h00;
         ptr_ff   <= 8'h00;
         rw_ff    <= 1'b0;
         first_ff <= 1'b0;
         acked_ff <= 1'b0;
         wr_ff    <= 1'b0;
         wd_ff    <= 8'h00;
         sda_oe_n <= 1'b1;
      end else begin
         scl_q_ff <= scl;
         sda_q_ff <= sda_in;
         wr_ff    <= 1'b0;
         if (wr_ff) begin
            ptr_ff <= ptr_ff + 8'h01;  // Advance after each stored byte
         end
         if (start_c) begin
            st_ff    <= ctr_pkg::I2C_ADDR;
            bit_ff   <= 3'h0;
            first_ff <= 1'b1;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            st_ff    <= ctr_pkg::I2C_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (st_ff)
               ctr_pkg::I2C_ADDR, ctr_pkg::I2C_WR: begin
                  if (scl_rise) begin
                     shift_ff <= rx_byte;
                     bit_ff   <= bit_ff + 3'h1;
                     acked_ff <= 1'b0;
                     if (bit_ff == 3'h7) begin
                        if (st_ff == ctr_pkg::I2C_ADDR) begin
                           rw_ff <= rx_byte[0];
                           st_ff <= (rx_byte[7:1] == DEV_ADDR) ? ctr_pkg::I2C_ACK
                                                              : ctr_pkg::I2C_IDLE;
                        end else begin
                           st_ff    <= ctr_pkg::I2C_ACK;
                           first_ff <= 1'b0;
                           if (first_ff) begin
                              ptr_ff <= rx_byte;  // First byte sets the pointer
                           end else begin
                              wr_ff <= 1'b1;
                              wd_ff <= rx_byte;
                           end
                        end
                     end
                  end
               end
               ctr_pkg::I2C_ACK: begin
                  if (scl_fall) begin
                     if (!acked_ff) begin
                        sda_oe_n <= 1'b0;  // Pull low for acknowledge
                        acked_ff <= 1'b1;
                     end else if (rw_ff) begin
                        shift_ff <= regs.rdata;
                        sda_oe_n <= regs.rdata[7];
                        ptr_ff   <= ptr_ff + 8'h01;
                        bit_ff   <= 3'h0;
                        st_ff    <= ctr_pkg::I2C_RD;
                     end else begin
                        sda_oe_n <= 1'b1;
                        bit_ff   <= 3'h0;
                        st_ff    <= ctr_pkg::I2C_WR;
                     end
                  end
               end
               ctr_pkg::I2C_RD: begin
                  if (scl_fall) begin
                     bit_ff <= bit_ff + 3'h1;
                     if (bit_ff == 3'h7) begin
                        sda_oe_n <= 1'b1;
                        st_ff    <= ctr_pkg::I2C_RACK;
                     end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sda_oe_n <= shift_ff[6];
                     end
                  end
               end
               ctr_pkg::I2C_RACK: begin
                  if (scl_rise) begin
                     acked_ff <= 1'b1;
                     st_ff    <= sda_in ? ctr_pkg::I2C_IDLE : ctr_pkg::I2C_ACK;
                  end
               end
               default: begin
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule : ctr_i2c_slave
`default_nettype wire

// File: logic/ctr_watchdog.sv
// Host watchdog: expires when no host write arrives within the period.
// Assumes kick is a one-cycle pulse from the register bank.
`timescale 1ns/1ps
`default_nettype none
module ctr_watchdog #(
   parameter int CYC_PER_MS = ctr_pkg::CYC_PER_MS
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       kick,
   input  wire logic [2:0] period_code,
   output logic            expire_ff
);
   localparam int PW = $clog2(CYC_PER_MS + 1);
   logic [PW-1:0]                 pre_ff;
   logic [ctr_pkg::WD_MS_W-1:0]   ms_ff;

   wire [ctr_pkg::WD_MS_W-1:0] limit = ctr_pkg::wd_limit_ms(period_code);
   wire ms_tick = (pre_ff == PW'(CYC_PER_MS - 1));
   wire idle    = kick | (period_code == 3'h0);
   wire hit     = ms_tick & (ms_ff == limit - 18'h00001);

   // Millisecond prescaler and period counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff    <= '0;
         ms_ff     <= '0;
         expire_ff <= 1'b0;
      end else begin
         expire_ff <= ~idle & hit;
         pre_ff    <= (idle | ms_tick) ? '0 : pre_ff + PW'(1);
         ms_ff     <= (idle | hit) ? '0 : (ms_tick ? ms_ff + 18'h00001 : ms_ff);
      end
   end
endmodule : ctr_watchdog
`default_nettype wire

// File: tb/ctr_timer_regs_chk.sv
// Checker for the configuration bank, watching top-level ports only.
// Assumes the bank is bound by the bind statement below.
`timescale 1ns/1ps
`default_nettype none
module ctr_timer_regs_chk (
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic [1:0]  fast_charge_entry_ratio,
   input wire logic [5:0]  precharge_current,
   input wire logic [4:0]  termination_current,
   input wire logic [10:0] output_voltage_target,
   input wire logic [6:0]  output_current_limit,
   input wire logic        timer_slowdown_enable,
   input wire logic        input_power_limiting,
   input wire logic        thermal_reg_active,
   input wire logic        timer_half_rate,
   input wire logic        timer_restart,
   input wire logic        wd_expired
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Clamped fields never leave their ranges
   property p_pre_min; precharge_current != 6'h00; endproperty
   a_pre_min: assert property (p_pre_min) else $error("precharge low");
   property p_term_min; termination_current != 5'h00; endproperty
   a_term_min: assert property (p_term_min) else $error("termination low");
   property p_iout_min; output_current_limit >= 7'h03; endproperty
   a_iout_min: assert property (p_iout_min) else $error("current low");
   property p_vout_max; output_voltage_target <= 11'h780; endproperty
   a_vout_max: assert property (p_vout_max) else $error("voltage high");
   // Half rate follows enable and limiting one cycle later
   property p_half;
      $past(arst_n, 4) |-> timer_half_rate ==
         $past(timer_slowdown_enable & (input_power_limiting | thermal_reg_active));
   endproperty
   a_half: assert property (p_half) else $error("half rate wrong");
   // Watchdog restore puts back the defaults
   property p_wd;
      wd_expired |-> precharge_current == 6'h03 && termination_current == 5'h05
         && output_current_limit == 7'h4b;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog restore wrong");
   // Soft reset restores ratio, precharge current and output voltage defaults
   property p_rst;
      timer_restart |-> fast_charge_entry_ratio == 2'h3 && precharge_current == 6'h03
         && output_voltage_target == 11'h0dc;
   endproperty
   a_rst: assert property (p_rst) else $error("soft reset wrong");
   property p_rst_pulse; timer_restart |=> !timer_restart; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("restart too long");
endmodule : ctr_timer_regs_chk
bind ctr_timer_regs ctr_timer_regs_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .fast_charge_entry_ratio(fast_charge_entry_ratio), .precharge_current(precharge_current),
   .termination_current(termination_current), .output_voltage_target(output_voltage_target),
   .output_current_limit(output_current_limit), .timer_slowdown_enable(timer_slowdown_enable),
   .input_power_limiting(input_power_limiting), .thermal_reg_active(thermal_reg_active),
   .timer_half_rate(timer_half_rate), .timer_restart(timer_restart), .wd_expired(wd_expired));
`default_nettype wire

// File: tb/ctr_host_model.sv
// Serial bus host model: register writes and pointer reads.
// Assumes the device pulls sda low only through sda_oe_n.
`timescale 1ns/1ps
`default_nettype none
module ctr_host_model (
   input  wire logic clk,
   input  wire logic sda_oe_n,
   output logic      scl,
   output logic      sda_in
);
   logic sda_h = 1'b1;
   logic [7:0] q;
   initial scl = 1'b1;
   // Open-drain wire with pull-up
   assign sda_in = sda_h & sda_oe_n;
   task automatic w3();
      repeat (3) @(posedge clk);
   endtask : w3
   // Start or repeated start
   task automatic start();
      sda_h <= 1'b1; w3(); scl <= 1'b1; w3(); sda_h <= 1'b0; w3(); scl <= 1'b0; w3();
   endtask : start
   task automatic stop();
      sda_h <= 1'b0; w3(); scl <= 1'b1; w3(); sda_h <= 1'b1; w3();
   endtask : stop
   // Byte out, byte in; ninth bit released: ack slot or final nack
   task automatic xb(input logic [7:0] d, output logic [7:0] r);
      for (int i = 8; i >= 0; i--) begin
         sda_h <= (i == 0) ? 1'b1 : d[i-1]; w3();
         scl <= 1'b1; w3();
         if (i > 0) r[i-1] = sda_in;
         scl <= 1'b0; w3();
      end
   endtask : xb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start(); xb(8'h54, q); xb(a, q); xb(d, q); stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      start(); xb(8'h54, q); xb(a, q); start(); xb(8'h55, q); xb(8'hff, d); stop();
   endtask : rd
endmodule : ctr_host_model
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: register traffic through the host model with expected values.
// Assumes the checker is bound to the bank by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] cell_strap = 2'h0;
   logic [2:0] wd_code = 3'h0;
   logic lim = 1'b0;
   logic therm = 1'b0;
   logic [7:0] d;
   int errors = 0;
   int tests_run = 0;
   int n;
   wire logic scl, sda_in, sda_oe_n, half, wdx;
   wire logic [1:0] ratio, cells;
   wire logic [5:0] pre, rch_o;
   wire logic [4:0] term_o;
   wire logic [7:0] tmr_o, iout_o;
   wire logic [10:0] vout, blim;
   logic [7:0] ro [9] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
   logic [7:0] rv [9] = '{8'h00, 8'hc3, 8'h05, 8'h23, 8'h00, 8'hdc, 8'h4b, 8'h3d, 8'h00};
   logic [7:0] wv [7] = '{8'h40, 8'h20, 8'hc0, 8'h07, 8'hff, 8'h81, 8'hc2};
   logic [7:0] we [7] = '{8'h41, 8'h21, 8'hc0, 8'h07, 8'h80, 8'h83, 8'hc2};
   always #25 ref_clk = ~ref_clk;
   ctr_host_model i_host (.clk(ref_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in));
   ctr_timer_regs #(.CYC_PER_MS(4)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .scl(scl),
      .sda_in(sda_in), .sda_out(), .sda_oe_n(sda_oe_n), .cell_strap(cell_strap),
      .wd_period_code(wd_code), .input_power_limiting(lim), .thermal_reg_active(therm),
      .fast_charge_entry_ratio(ratio), .precharge_current(pre), .termination_current(term_o),
      .cell_count(cells), .recharge_deglitch(rch_o[5:4]), .recharge_offset(rch_o[3:0]),
      .output_voltage_target(vout), .output_current_limit(iout_o[6:0]),
      .precharge_timer_length(iout_o[7]), .topoff_duration(tmr_o[7:6]),
      .trickle_timer_enable(tmr_o[5]), .precharge_timer_enable(tmr_o[4]),
      .fast_timer_enable(tmr_o[3]), .fast_timer_length(tmr_o[2:1]),
      .timer_slowdown_enable(tmr_o[0]), .timer_half_rate(half),
      .battery_regulation_limit(blim), .timer_restart(), .wd_expired(wdx));
   task automatic chk(input logic [10:0] g, input logic [10:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, d); chk({3'h0, d}, {3'h0, e});
   endtask : rc
   task automatic conclude();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(blim, 11'h1a4);
      foreach (ro[i]) rc(ro[i], rv[i]);
      foreach (wv[i]) begin
         i_host.wr(ro[i+1], wv[i]);
         rc(ro[i+1], we[i]);
      end
      chk({9'h0, ratio}, 11'h001);
      chk({5'h0, pre}, 11'h001);
      chk(vout, 11'h780);
      chk({6'h0, term_o}, 11'h001);
      chk({3'h0, iout_o}, 11'h083);
      chk({3'h0, tmr_o}, 11'h0c2);
      cell_strap <= 2'h2;
      i_host.wr(8'h09, 8'h40);
      rc(8'h09, 8'h05);
      rc(8'h08, 8'hc3);
      rc(8'h0e, 8'h3d);
      rc(8'h0a, 8'ha3);
      chk({9'h0, cells}, 11'h002);
      chk(blim, 11'h4ec);
      chk({5'h0, rch_o}, 11'h023);
      i_host.wr(8'h08, 8'h40);
      i_host.wr(8'h0a, 8'hc0);
      wd_code <= 3'h1;
      for (n = 0; n < 3000 && wdx !== 1'b1; n++) @(posedge ref_clk);
      chk({10'h0, n < 3000}, 11'h001);
      wd_code <= 3'h0;
      rc(8'h08, 8'h43);
      rc(8'h0a, 8'he3);
      chk({3'h0, tmr_o}, 11'h03d);
      chk({3'h0, iout_o}, 11'h04b);
      lim <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk({10'h0, half}, 11'h001);
      i_host.wr(8'h0e, 8'h3c);
      chk({10'h0, half}, 11'h000);
      chk({3'h0, tmr_o}, 11'h03c);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
